// >>> mcs_far_side.sv
// Purpose: far side line partner model, one per port
// Assumes: mode changes right after a clock edge
// Notes:   mode 0 silent, 1 autoneg, 2 10M signal, 3 100M signal
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// model
module mcs_far_side
  import mcs_pkg::*;
(
  // control
  input  wire logic [1:0]   mode_i,
  input  wire logic         pkt_i,
  input  wire logic         link_i,
  // line state
  output var  mcs_port_in_s port_o
);
  // packets only ride on a running rate
  assign port_o = {link_i, pkt_i & mode_i[1], mode_i == 2'h1,
                   mode_i == 2'h2, mode_i == 2'h3};
endmodule
`default_nettype wire

// >>> mcs_pkg.sv
// Purpose: shared constants and types of the strap and status block
// Assumes: core clock mclk_i at 40 MHz
// Notes:   times are kept in their own unit, counts derived from them
// ==========================================================
// package
package mcs_pkg;
  // ========================================================
  // clock and times
  localparam int CLK_KHZ         = 40000;
  localparam int STRETCH_US      = 1300;
  localparam int STRETCH_FAST_MS = 163;
  localparam int INIT_US         = 3000;
  localparam int WARN_PER_MS     = 3800;
  localparam int WARN_OFF_MS     = 425;
  localparam int WARN_PER_F_MS   = 934;
  localparam int WARN_OFF_F_MS   = 104;
  // least times round up, interval times round down
  localparam int STRETCH_CYC      = (STRETCH_US * CLK_KHZ + 999) / 1000;
  localparam int STRETCH_FAST_CYC = STRETCH_FAST_MS * CLK_KHZ;
  localparam int INIT_CYC         = (INIT_US * CLK_KHZ + 999) / 1000;
  localparam int WARN_PER_CYC     = WARN_PER_MS * CLK_KHZ;
  localparam int WARN_OFF_CYC     = WARN_OFF_MS * CLK_KHZ;
  localparam int WARN_PER_F_CYC   = WARN_PER_F_MS * CLK_KHZ;
  localparam int WARN_OFF_F_CYC   = WARN_OFF_F_MS * CLK_KHZ;
  // ========================================================
  // registers
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STAT     = 8'h04;
  localparam int         CTRL_W       = 5;
  localparam logic [4:0] CTRL_RST     = 5'h00;
  localparam int         CTRL_FAST    = 0;
  localparam int         CTRL_SCR_INV = 1;
  localparam int         CTRL_DIS100  = 2;
  localparam int         CTRL_DIS10   = 3;
  localparam int         CTRL_TESTOUT = 4;
  localparam int         STAT_W       = 18;
  // ========================================================
  // three-level strap codes
  localparam logic [1:0] LVL_HI = 2'h2;
  localparam logic [1:0] LVL_LO = 2'h1;
  // ========================================================
  // types
  typedef enum logic [1:0] {
    ST_PD   = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10
  } mcs_state_e;
  typedef struct packed {
    logic link_up;
    logic pkt;
    logic aneg;
    logic sig10;
    logic sig100;
  } mcs_port_in_s;
  typedef struct packed {
    logic [1:0] duplex;
    logic [1:0] speed;
    logic [1:0] tp_sel;
    logic [1:0] fo_sel;
    logic [1:0] addr4;
    logic [1:0] addr32;
    logic [1:0] addr10;
  } mcs_strap_s;
endpackage

// >>> mcs_strap_status.sv
// Purpose: strap decode, indicator drive and link warning gating
// Assumes: pins asynchronous to mclk_i, register port synchronous
// Notes:   index 0 is the twisted-pair port, index 1 the fiber port
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// How it works
// - speed pin high 100M, low 10M, else float
// - speed floating: activity low on autoneg
// - speed driven: activity low on packet
// - packet low stretched, longer in test mode
// - activity floats otherwise unless test output
// - tp select: magnetics or PECL module
// - PECL tp: scrambler off unless bit set
// - magnetics tp: scrambler on unless bit set
// - tp short length: slice without equalizer
// - fiber select: PECL module or LED driver
// - LED short length: raised detect thresholds
// - one strap gives address bit4 and warning
// - two straps give address bits 3:2, 1:0
// - warning only with exactly one speed
// - link down: transmitter off periodically
// - both links down: no transmit output
// - duplex float and speed float: transparent, else not
// - speed float: both rates allowed
// - tp disable low turns tp output off
// - speed high: 100M only, no autoneg
// - speed ground: 10M only, no autoneg
// - straps sampled 3ms after power-up
// - all timers run on the core clock
module mcs_strap_status
  import mcs_pkg::*;
#(
  parameter int unsigned CW        = 28,
  parameter int unsigned STR_CYC   = STRETCH_CYC,
  parameter int unsigned STR_F_CYC = STRETCH_FAST_CYC,
  parameter int unsigned INI_CYC   = INIT_CYC,
  parameter int unsigned PER_CYC   = WARN_PER_CYC,
  parameter int unsigned OFF_CYC   = WARN_OFF_CYC,
  parameter int unsigned PER_F_CYC = WARN_PER_F_CYC,
  parameter int unsigned OFF_F_CYC = WARN_OFF_F_CYC
) (
  // clock and reset
  input  wire  logic         mclk_i,
  input  wire  logic         arst_n_i,
  // register port
  input  wire  logic [7:0]   reg_addr_i,
  input  wire  logic [31:0]  reg_wdata_i,
  input  wire  logic         reg_wr_i,
  input  wire  logic         reg_rd_i,
  output logic       [31:0]  reg_rdata_o,
  // pins
  input  wire  logic         power_down_n_i,
  input  wire  logic         tp_output_disable_i,
  input  wire  logic         backup_link_enable_i,
  input  wire  mcs_strap_s   strap_i,
  input  wire  mcs_port_in_s tp_rx_i,
  input  wire  mcs_port_in_s fiber_rx_i,
  // indicators
  output logic               tp_speed_indicator_o,
  output logic               tp_speed_indicator_oe_n_o,
  output logic               fiber_speed_indicator_o,
  output logic               fiber_speed_indicator_oe_n_o,
  output logic               tp_activity_indicator_o,
  output logic               tp_activity_indicator_oe_n_o,
  output logic               fiber_activity_indicator_o,
  output logic               fiber_activity_indicator_oe_n_o,
  // transmitter gating
  output logic               tp_tx_en_o,
  output logic               fiber_tx_en_o,
  // configuration
  output logic               tp_pecl_mode_o,
  output logic               fiber_pecl_mode_o,
  output logic               scrambler_en_o,
  output logic               eq_bypass_o,
  output logic               sd_thresh_raised_o,
  output logic       [4:0]   phy_addr_o,
  output logic               duplex_transparent_o,
  output logic               allow_100_o,
  output logic               allow_10_o,
  output logic               aneg_allow_o,
  output logic               secondary_link_en_o,
  output logic               ready_o
);

  // ========================================================
  // parameter check
  if (PER_CYC >= 2**CW || PER_F_CYC >= 2**CW || STR_F_CYC >= 2**CW ||
      INI_CYC >= 2**CW || OFF_CYC >= PER_CYC || OFF_F_CYC >= PER_F_CYC ||
      STR_CYC < 1 || STR_F_CYC < 1 || INI_CYC < 1) begin : g_bad
    $error("timer parameters out of range");
  end

  // ========================================================
  // functions
  function automatic logic lvl_float(input logic [1:0] c);
    lvl_float = (c != LVL_HI) && (c != LVL_LO);
  endfunction

  // ========================================================
  // input synchronisers
  localparam int SW = 3 + $bits(mcs_strap_s) + 2 * $bits(mcs_port_in_s);
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {power_down_n_i, tp_output_disable_i, backup_link_enable_i,
               strap_i, fiber_rx_i, tp_rx_i};
      s2_r <= s1_r;
    end
  end

  logic                pdn_s;
  logic                tpoff_s;
  logic                bkp_s;
  mcs_strap_s          strap_s;
  mcs_port_in_s [1:0]  rx_w;
  assign {pdn_s, tpoff_s, bkp_s, strap_s, rx_w} = s2_r;

  // ========================================================
  // power-up sequencing
  mcs_state_e    state_r;
  mcs_state_e    state_nxt;
  logic [CW-1:0] icnt_r;
  logic          run_w;
  logic          cap_w;
  assign run_w = (state_r == ST_RUN);
  assign cap_w = (state_r == ST_WAIT) && pdn_s &&
                 (icnt_r == CW'(INI_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_PD:   if (pdn_s) state_nxt = ST_WAIT;
      ST_WAIT: begin
        if (!pdn_s) state_nxt = ST_PD;
        else if (cap_w) state_nxt = ST_RUN;
      end
      ST_RUN:  if (!pdn_s) state_nxt = ST_PD;
      default: state_nxt = ST_PD;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_PD;
      icnt_r  <= '0;
    end else begin
      state_r <= state_nxt;
      icnt_r  <= (state_r == ST_WAIT) ? icnt_r + 1'b1 : '0;
    end
  end

  // ========================================================
  // strap capture and control register
  mcs_strap_s        strap_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic              wr_ctrl_w;
  assign wr_ctrl_w = reg_wr_i && (reg_addr_i == REG_CTRL);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_r <= '0;
      ctrl_r  <= CTRL_RST;
    end else if (cap_w) begin
      strap_r <= strap_s;
      ctrl_r  <= CTRL_RST;
    end else if (wr_ctrl_w) begin
      ctrl_r  <= reg_wdata_i[CTRL_W-1:0];
    end
  end

  logic fast_w;
  logic test_out_w;
  assign fast_w     = ctrl_r[CTRL_FAST];
  assign test_out_w = ctrl_r[CTRL_TESTOUT];

  // ========================================================
  // strap decode
  logic spd_hi_w;
  logic spd_lo_w;
  logic one_speed_w;
  logic liw_en_w;
  logic liw_act_w;
  assign spd_hi_w = (strap_r.speed == LVL_HI);
  assign spd_lo_w = (strap_r.speed == LVL_LO);
  assign allow_100_o  = run_w && !spd_lo_w && !ctrl_r[CTRL_DIS100];
  assign allow_10_o   = run_w && !spd_hi_w && !ctrl_r[CTRL_DIS10];
  assign aneg_allow_o = run_w && lvl_float(strap_r.speed);
  assign duplex_transparent_o = aneg_allow_o &&
                                lvl_float(strap_r.duplex);
  assign tp_pecl_mode_o    = strap_r.tp_sel[1];
  assign fiber_pecl_mode_o = strap_r.fo_sel[1];
  assign scrambler_en_o = strap_r.tp_sel[1] ? ctrl_r[CTRL_SCR_INV]
                                            : !ctrl_r[CTRL_SCR_INV];
  assign eq_bypass_o = !strap_r.tp_sel[1] && strap_r.tp_sel[0];
  assign sd_thresh_raised_o = !strap_r.fo_sel[1] &&
                              strap_r.fo_sel[0];
  assign phy_addr_o = {strap_r.addr4[1], strap_r.addr32,
                       strap_r.addr10};
  assign liw_en_w    = strap_r.addr4[0];
  assign one_speed_w = allow_100_o ^ allow_10_o;
  assign liw_act_w   = run_w && liw_en_w && one_speed_w;
  assign secondary_link_en_o = run_w && !bkp_s;
  assign ready_o = run_w;

  // ========================================================
  // link warning timer
  logic [CW-1:0] wcnt_r;
  logic [CW-1:0] per_w;
  logic [CW-1:0] off_w;
  logic          off_win_w;
  assign per_w = fast_w ? CW'(PER_F_CYC) : CW'(PER_CYC);
  assign off_w = fast_w ? CW'(OFF_F_CYC) : CW'(OFF_CYC);
  assign off_win_w = liw_act_w && (wcnt_r < off_w);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wcnt_r <= '0;
    end else if (!liw_act_w || wcnt_r >= per_w - 1'b1) begin
      wcnt_r <= '0;
    end else begin
      wcnt_r <= wcnt_r + 1'b1;
    end
  end

  logic       both_dn_w;
  logic [1:0] tx_en_w;
  assign both_dn_w = liw_act_w && !rx_w[0].link_up &&
                     !rx_w[1].link_up;
  assign tx_en_w[0] = run_w && tpoff_s && !both_dn_w &&
                      !(off_win_w && !rx_w[0].link_up);
  assign tx_en_w[1] = run_w && !both_dn_w &&
                      !(off_win_w && !rx_w[1].link_up);

  // ========================================================
  // per-port stretch and indicators
  logic [CW-1:0] scnt_r [2];
  logic [CW-1:0] slen_w;
  logic [1:0]    spd_drv_w;
  logic [1:0]    pkt_w;
  logic [1:0]    act_low_w;
  logic [1:0]    spd_r;
  logic [1:0]    spd_oe_n_r;
  logic [1:0]    act_r;
  logic [1:0]    act_oe_n_r;
  logic [1:0]    tx_r;
  assign slen_w = fast_w ? CW'(STR_F_CYC - 1) : CW'(STR_CYC - 1);

  for (genvar p = 0; p < 2; p++) begin : g_port
    assign spd_drv_w[p] = rx_w[p].sig100 || rx_w[p].sig10;
    assign pkt_w[p] = spd_drv_w[p] && rx_w[p].pkt;
    assign act_low_w[p] = spd_drv_w[p] ? (pkt_w[p] || scnt_r[p] != '0)
                                       : rx_w[p].aneg;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        scnt_r[p] <= '0;
      end else if (!run_w) begin
        scnt_r[p] <= '0;
      end else if (pkt_w[p]) begin
        scnt_r[p] <= slen_w;
      end else if (scnt_r[p] != '0) begin
        scnt_r[p] <= scnt_r[p] - 1'b1;
      end
    end
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        spd_r[p]      <= 1'b0;
        spd_oe_n_r[p] <= 1'b1;
        act_r[p]      <= 1'b0;
        act_oe_n_r[p] <= 1'b1;
        tx_r[p]       <= 1'b0;
      end else begin
        spd_r[p]      <= rx_w[p].sig100;
        spd_oe_n_r[p] <= !(run_w && spd_drv_w[p]);
        act_r[p]      <= test_out_w && tx_en_w[p];
        act_oe_n_r[p] <= !(run_w && (test_out_w || act_low_w[p]));
        tx_r[p]       <= tx_en_w[p];
      end
    end
  end

  assign tp_speed_indicator_o            = spd_r[0];
  assign tp_speed_indicator_oe_n_o       = spd_oe_n_r[0];
  assign fiber_speed_indicator_o         = spd_r[1];
  assign fiber_speed_indicator_oe_n_o    = spd_oe_n_r[1];
  assign tp_activity_indicator_o         = act_r[0];
  assign tp_activity_indicator_oe_n_o    = act_oe_n_r[0];
  assign fiber_activity_indicator_o      = act_r[1];
  assign fiber_activity_indicator_oe_n_o = act_oe_n_r[1];
  assign tp_tx_en_o                      = tx_r[0];
  assign fiber_tx_en_o                   = tx_r[1];

  // ========================================================
  // register read
  logic [STAT_W-1:0] stat_w;
  logic [31:0]       rmux_w;
  logic [31:0]       rdata_r;
  assign stat_w = {rx_w[1].link_up, rx_w[0].link_up, run_w,
                   strap_r.fo_sel, strap_r.tp_sel, duplex_transparent_o,
                   aneg_allow_o, allow_10_o, allow_100_o, liw_act_w,
                   liw_en_w, phy_addr_o};
  assign rmux_w = (reg_addr_i == REG_CTRL) ? 32'(ctrl_r) :
                  (reg_addr_i == REG_STAT) ? 32'(stat_w) : 32'h0000_0000;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= reg_rd_i ? rmux_w : 32'h0000_0000;
    end
  end
  assign reg_rdata_o = rdata_r;

  // ========================================================
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_spd_hundred: assert property (
    run_w && rx_w[0].sig100 |=> !tp_speed_indicator_oe_n_o &&
                                tp_speed_indicator_o)
    else $error("speed pin not high at 100M");
  a_spd_float: assert property (
    !spd_drv_w[1] |=> fiber_speed_indicator_oe_n_o)
    else $error("speed pin driven without signal");
  a_act_aneg: assert property (
    run_w && !spd_drv_w[0] && rx_w[0].aneg
    |=> !tp_activity_indicator_oe_n_o)
    else $error("activity not low on autoneg");
  a_act_pkt: assert property (
    run_w && pkt_w[1] && !test_out_w
    |=> !fiber_activity_indicator_oe_n_o && !fiber_activity_indicator_o)
    else $error("activity not low on packet");
  a_stretch_len: assert property (
    run_w && pkt_w[0] && !fast_w |=> scnt_r[0] == CW'(STR_CYC - 1))
    else $error("stretch length wrong");
  a_stretch_hold: assert property (
    run_w && $fell(pkt_w[0]) && spd_drv_w[0] && !test_out_w
    |-> ##1 !tp_activity_indicator_oe_n_o [*2])
    else $error("stretch dropped early");
  a_act_idle: assert property (
    !test_out_w && !act_low_w[0] |=> tp_activity_indicator_oe_n_o)
    else $error("activity driven while idle");
  a_addr_cap: assert property (
    $rose(run_w) |-> phy_addr_o[3:0] ==
                     {$past(strap_s.addr32), $past(strap_s.addr10)})
    else $error("address straps not captured");
  a_one_speed: assert property (
    !one_speed_w |-> !liw_act_w && !off_win_w ##1 wcnt_r == '0)
    else $error("warning active with two speeds");
  a_liw_gate: assert property (
    off_win_w && !rx_w[0].link_up |=> !tp_tx_en_o)
    else $error("tp transmitter not gated");
  a_both_down: assert property (
    liw_act_w && !rx_w[0].link_up && !rx_w[1].link_up
    |=> !tp_tx_en_o && !fiber_tx_en_o)
    else $error("output while both links down");
  a_tp_off: assert property (
    !tpoff_s |=> !tp_tx_en_o)
    else $error("tp output not disabled");
  a_init_wait: assert property (
    $rose(run_w) |-> $past(state_r) == ST_WAIT &&
                     $past(icnt_r) == CW'(INI_CYC - 1))
    else $error("run entered before init time");

  c_stretch: cover property (run_w && $fell(pkt_w[0]) ##1 scnt_r[0] != '0);
  c_liw_off: cover property (off_win_w && !rx_w[1].link_up);
  c_run:     cover property ($rose(run_w));
  c_aneg:    cover property (run_w && !spd_drv_w[1] && rx_w[1].aneg);

endmodule
`default_nettype wire

// >>> mcs_strap_status_test.sv
// Purpose: self-checking bench for the strap and status block
// Assumes: shortened timer counts, 40 MHz clock
// Notes:   strap rows and indicator cases in tables, stretch and gating by hand
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// bench
module mcs_strap_status_test
  import mcs_pkg::*;
;
  localparam int INI  = 20;
  localparam int STR  = 8;
  localparam int STRF = 16;
  localparam int PER  = 40;
  localparam int OFF  = 5;
  localparam int PERF = 20;
  localparam int OFFF = 3;
  logic         clk = 1'h0;
  logic         rst_n = 1'h0;
  logic [7:0]   ra = 8'h00;
  logic [31:0]  wd = 32'h0;
  logic         we = 1'h0;
  logic         re = 1'h0;
  logic         pd_n = 1'h0;
  logic         tp_on = 1'h1;
  logic         bk = 1'h1;
  logic         pk = 1'h0;
  logic         tp_lk = 1'h1;
  logic         fo_lk = 1'h1;
  logic [1:0]   md = 2'h0;
  mcs_strap_s   strap = 14'h0;
  mcs_port_in_s tp_rx, fo_rx;
  logic [31:0]  rdata, v, e, g;
  logic         tp_sp, tp_sz, fo_sp, fo_sz, tp_ac, tp_az, fo_ac, fo_az;
  logic         tp_tx, fo_tx, tp_pe, fo_pe, scr, eqb, sdt, dup, sec, rdy;
  logic         a100, a10, anen;
  logic [4:0]   phy;
  int           failures = 0;
  int           check_count = 0;
  int           n;
  logic [13:0]  strap_tab [4] = '{14'h0067, 14'h2AD8, 14'h150D, 14'h3FB2};
  logic [13:0]  exp_tab [4] = '{14'h2FE5, 14'h1118, 14'h1A86, 14'h25F8};
  logic [6:0]   act_tab [5] = '{7'h0B, 7'h28, 7'h43, 7'h67, 7'h74};
  // ========================================================
  // clock, design and line partners
  always #12.5 clk = ~clk;
  mcs_strap_status #(
    .STR_CYC(STR), .STR_F_CYC(STRF), .INI_CYC(INI), .PER_CYC(PER),
    .OFF_CYC(OFF), .PER_F_CYC(PERF), .OFF_F_CYC(OFFF)
  ) dut (
    .mclk_i(clk), .arst_n_i(rst_n), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdata),
    .power_down_n_i(pd_n), .tp_output_disable_i(tp_on),
    .backup_link_enable_i(bk), .strap_i(strap), .tp_rx_i(tp_rx),
    .fiber_rx_i(fo_rx), .tp_speed_indicator_o(tp_sp),
    .tp_speed_indicator_oe_n_o(tp_sz), .fiber_speed_indicator_o(fo_sp),
    .fiber_speed_indicator_oe_n_o(fo_sz), .tp_activity_indicator_o(tp_ac),
    .tp_activity_indicator_oe_n_o(tp_az),
    .fiber_activity_indicator_o(fo_ac),
    .fiber_activity_indicator_oe_n_o(fo_az), .tp_tx_en_o(tp_tx),
    .fiber_tx_en_o(fo_tx), .tp_pecl_mode_o(tp_pe),
    .fiber_pecl_mode_o(fo_pe), .scrambler_en_o(scr), .eq_bypass_o(eqb),
    .sd_thresh_raised_o(sdt), .phy_addr_o(phy),
    .duplex_transparent_o(dup), .allow_100_o(a100), .allow_10_o(a10),
    .aneg_allow_o(anen), .secondary_link_en_o(sec), .ready_o(rdy)
  );
  mcs_far_side tp_far (
    .mode_i(md), .pkt_i(pk), .link_i(tp_lk), .port_o(tp_rx)
  );
  mcs_far_side fo_far (
    .mode_i(md), .pkt_i(pk), .link_i(fo_lk), .port_o(fo_rx)
  );
  // ========================================================
  // tasks
  task automatic give_verdict;
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] x,
                     input logic [31:0] y);
    check_count++;
    if (y !== x) begin
      failures++;
      $display("mismatch %s exp %h got %h", what, x, y);
    end
  endtask
  // one strobe cycle; read data lands in v
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    {we, re, ra, wd} <= {w, ~w, a, d};
    @(posedge clk);
    {we, re} <= 2'h0;
    #1;
    v = rdata;
  endtask
  // power down, set straps, power up and wait for capture
  task automatic load(input logic [13:0] s);
    @(posedge clk);
    pd_n <= 1'h0;
    strap <= s;
    step(4);
    g = 32'({rdy, tp_tx, fo_tx, tp_sz, tp_az});
    chk("powered down", 32'h3, g);
    @(posedge clk);
    pd_n <= 1'h1;
    n = 0;
    while (rdy !== 1'h1 && n < 60) begin
      step(1);
      n++;
    end
    chk("init time", 32'h1, 32'(n >= INI && n <= INI + 6));
    if (n == 60) give_verdict;
  endtask
  // count cycles with each transmitter held off over one window
  task automatic gate(input int len, input logic [15:0] want);
    logic [7:0] lt;
    logic [7:0] lf;
    lt = 8'h0;
    lf = 8'h0;
    step(45);
    repeat (len) begin
      lt += 8'(tp_tx !== 1'h1);
      lf += 8'(fo_tx !== 1'h1);
      step(1);
    end
    chk("tx off cycles", 32'(want), 32'({lt, lf}));
  endtask
  // ========================================================
  // sequence
  initial begin
    step(10);
    g = 32'({rdy, tp_sz, fo_sz, tp_az, fo_az, tp_tx, fo_tx});
    chk("reset state", 32'h3C, g);
    @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      load(strap_tab[i]);
      e = 32'(exp_tab[i]);
      g = 32'({phy, a100, a10, anen, dup, tp_pe, fo_pe, scr, eqb, sdt});
      chk("address", e & 32'h3E00, g & 32'h3E00);
      chk("speed", e & 32'h1E0, g & 32'h1E0);
      chk("media", e & 32'h18, g & 32'h18);
      chk("line", e & 32'h7, g & 32'h7);
    end
    bus(1'h0, 8'h00, 32'h0);
    chk("ctrl after capture", 32'h0, v);
    bus(1'h1, 8'h04, 32'hFFFF_FFFF);
    bus(1'h0, 8'h04, 32'h0);
    chk("status", 32'h3DFB2, v);
    bus(1'h0, 8'h08, 32'h0);
    chk("unmapped", 32'h0, v);
    bus(1'h1, 8'h00, 32'hFFFF_FFFF);
    bus(1'h0, 8'h00, 32'h0);
    chk("ctrl bits", 32'h1F, v);
    bus(1'h1, 8'h00, 32'h6);
    bus(1'h0, 8'h04, 32'h0);
    chk("one speed", 32'h5, (v >> 6) & 32'h7);
    chk("scrambler on", 32'h1, 32'(scr));
    load(strap_tab[0]);
    foreach (act_tab[i]) begin
      @(posedge clk);
      md <= act_tab[i][6:5];
      pk <= act_tab[i][4];
      step(4);
      e = 32'({2{act_tab[i][3:0]}});
      g = 32'({tp_sz, tp_sp & ~tp_sz, tp_az, tp_ac | tp_az,
               fo_sz, fo_sp & ~fo_sz, fo_az, fo_ac | fo_az});
      chk("indicators", e, g);
    end
    for (int f = 0; f < 2; f++) begin
      bus(1'h1, 8'h00, 32'(f));
      @(posedge clk);
      pk <= 1'h1;
      step(4);
      @(posedge clk);
      pk <= 1'h0;
      #1;
      n = 0;
      while (tp_az === 1'h0 && tp_ac === 1'h0 && n < 100) begin
        step(1);
        n++;
      end
      e = 32'(f ? STRF : STR);
      chk("stretch", 32'h1, 32'(n >= e && n <= 2 * e + 4));
      if (n == 100) give_verdict;
    end
    @(posedge clk);
    md <= 2'h0;
    bus(1'h1, 8'h00, 32'h12);
    step(4);
    g = 32'({tp_az, tp_ac, fo_az, fo_ac, scr});
    chk("test output", 32'hA, g);
    bus(1'h1, 8'h00, 32'h0);
    @(posedge clk);
    tp_lk <= 1'h0;
    bk <= 1'h0;
    gate(PER, 16'h0);
    chk("secondary link", 32'h1, 32'(sec));
    @(posedge clk);
    bk <= 1'h1;
    load(strap_tab[1]);
    chk("secondary link", 32'h0, 32'(sec));
    gate(PER, {8'(OFF), 8'h0});
    bus(1'h1, 8'h00, 32'h1);
    gate(PERF, {8'(OFFF), 8'h0});
    @(posedge clk);
    tp_lk <= 1'h1;
    fo_lk <= 1'h0;
    gate(PERF, {8'h0, 8'(OFFF)});
    @(posedge clk);
    tp_lk <= 1'h0;
    gate(PERF, {8'(PERF), 8'(PERF)});
    @(posedge clk);
    tp_lk <= 1'h1;
    fo_lk <= 1'h1;
    tp_on <= 1'h0;
    gate(PERF, {8'(PERF), 8'h0});
    give_verdict;
  end
endmodule
`default_nettype wire
